// ### src/btapr_consts.vh
`ifndef BTAPR_CONSTS_VH
`define BTAPR_CONSTS_VH
// Register addresses within the autonegotiation device
`define BTAPR_ADDR_ADV_LOW    16'h0202
`define BTAPR_ADDR_ADV_MID    16'h0203
`define BTAPR_ADDR_ADV_HIGH   16'h0204
`define BTAPR_ADDR_LP_LOW     16'h0205
`define BTAPR_ADDR_LP_MID     16'h0206
`define BTAPR_ADDR_LP_HIGH    16'h0207
`define BTAPR_ADDR_NP_LOW     16'h0208
`define BTAPR_ADDR_AN_STATUS  16'h0201
// Reset values
`define BTAPR_RST_ADV_LOW     16'h0001
`define BTAPR_RST_ADV_MID     16'h4000
`define BTAPR_RST_ADV_HIGH    16'h0000
`define BTAPR_RST_NP_LOW      16'h2001
`define BTAPR_SELECTOR_ETH    5'h01
// Writable-bit masks for local words; stored-bit masks for partner words
`define BTAPR_MASK_ADV_LOW    16'h3C00
`define BTAPR_MASK_ADV_MID    16'h4010
`define BTAPR_MASK_ADV_HIGH   16'h3000
`define BTAPR_MASK_NP_LOW     16'hB7FF
`define BTAPR_MASK_LP_LOW     16'hFC1F
`define BTAPR_MASK_LP_MID     16'h40F0
`define BTAPR_MASK_LP_HIGH    16'h7800
// Field positions
`define BTAPR_BIT_ROLE        4
`define BTAPR_BIT_HI_ABL      13
`define BTAPR_BIT_HI_REQ      12
`define BTAPR_BIT_PAGE_RX     6
`endif

// ### src/btapr_sync.v
`timescale 1ns/1ps
// Three-stage synchroniser; output moves when stages two and three agree
module btapr_sync #(
  parameter WIDTH = 3
) (
  input  wire             core_clk_i,
  input  wire             arst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      always @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          s1_q[g]   <= 1'b0;
          s2_q[g]   <= 1'b0;
          s3_q[g]   <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= async_i[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            sync_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate
endmodule // btapr_sync

// ### src/btapr_snap.v
`timescale 1ns/1ps
// Snapshot register for the partner middle and high words
module btapr_snap #(
  parameter WIDTH = 32
) (
  input  wire             core_clk_i,
  input  wire             arst_n_i,
  input  wire             capture_i,
  input  wire [WIDTH-1:0] live_i,
  output reg  [WIDTH-1:0] held_o
);
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      held_o <= {WIDTH{1'b0}};
    else if (capture_i)
      held_o <= live_i;
  end
endmodule // btapr_snap

// ### src/btapr_regs.v
`timescale 1ns/1ps
`include "btapr_consts.vh"
// Notes on behaviour
// - Local selector is read-only and always reads 00001.
// - Force bit 12: zero means preferred role, one means forced role.
// - Bits 11:10 of the low advert word hold writable pause capability.
// - Middle advert bit 14 long-reach ability, writable, resets to one.
// - Middle advert bit 4 role choice, reset from strap pins.
// - High advert bit 13 high amplitude ability, reset from straps.
// - High advert bit 12 high amplitude request, reset from straps.
// - Either side lacks high ability: both use low amplitude.
// - Both able and either requests: high amplitude, else low.
// - Reading partner low word snapshots partner middle and high words.
// - Partner middle and high reads return the snapshot, not live data.
// - Partner low word reports next page, ack, fault, pause, selector.
// - Partner low bit 12 reports partner forced or preferred role.
// - Partner middle reports long-reach, gigabit, short-reach FD, 100M.
// - Partner middle bit 4 reports partner role choice.
// - Partner high reports energy saving, high ability, request, T1S HD.
// - Next page low word resets to 0x2001, a null message page.
// - Next page low bit 15 requests a further next page.
// - Page arrived flag sets on stored codeword, clears on status read.
module btapr_regs (
  input  wire        core_clk_i,
  input  wire        arst_n_i,
  input  wire        an_reset_i,
  input  wire [2:0]  strap_pins_i,
  input  wire        reg_rd_i,
  input  wire        reg_wr_i,
  input  wire [15:0] reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        page_valid_i,
  input  wire [47:0] page_data_i,
  input  wire        an_enabled_i,
  output reg  [15:0] reg_rdata_o,
  output reg         reg_rvalid_o,
  output reg  [47:0] local_page_o,
  output reg  [15:0] next_page_low_o,
  output reg         page_arrived_flag_o,
  output reg         high_amplitude_o
);
  reg  [15:0] adv_low_q;
  reg  [15:0] adv_mid_q;
  reg  [15:0] adv_high_q;
  reg  [15:0] np_low_q;
  reg  [47:0] lp_live_q;
  reg         page_arrived_flag_q;
  reg         strap_take_q;
  reg  [15:0] rdata_d;
  wire [2:0]  strap_s;
  wire [31:0] lp_held;
  wire        rd_lp_low;
  wire        rd_status;
  wire        local_able;
  wire        local_req;
  wire        lp_able;
  wire        lp_req;

  // Straps arrive from pins, so they are synchronised before use
  btapr_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .async_i    (strap_pins_i),
    .sync_o     (strap_s)
  );

  assign rd_lp_low = reg_rd_i && (reg_addr_i == `BTAPR_ADDR_LP_LOW);
  assign rd_status = reg_rd_i && (reg_addr_i == `BTAPR_ADDR_AN_STATUS);

  btapr_snap #(
    .WIDTH (32)
  ) u_snap (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .capture_i  (rd_lp_low),
    .live_i     (lp_live_q[47:16]),
    .held_o     (lp_held)
  );

  // Local advertisement and next page words
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      adv_low_q    <= `BTAPR_RST_ADV_LOW;
      adv_mid_q    <= `BTAPR_RST_ADV_MID;
      adv_high_q   <= `BTAPR_RST_ADV_HIGH;
      np_low_q     <= `BTAPR_RST_NP_LOW;
      strap_take_q <= 1'b1;
    end
    else if (an_reset_i)
    begin
      adv_low_q    <= `BTAPR_RST_ADV_LOW;
      adv_mid_q    <= `BTAPR_RST_ADV_MID;
      adv_high_q   <= `BTAPR_RST_ADV_HIGH;
      np_low_q     <= `BTAPR_RST_NP_LOW;
      strap_take_q <= 1'b1;
    end
    else if (strap_take_q)
    begin
      // Straps are caught in the first cycle after either reset, whether or not the synchroniser has settled
      adv_mid_q[`BTAPR_BIT_ROLE]    <= strap_s[0];
      adv_high_q[`BTAPR_BIT_HI_ABL] <= strap_s[1];
      adv_high_q[`BTAPR_BIT_HI_REQ] <= strap_s[2];
      strap_take_q                  <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        // Selector bits are outside the mask, so they stay 00001
        `BTAPR_ADDR_ADV_LOW:
          adv_low_q <= (reg_wdata_i & `BTAPR_MASK_ADV_LOW)
                       | {11'h000, `BTAPR_SELECTOR_ETH};
        `BTAPR_ADDR_ADV_MID:
          adv_mid_q <= reg_wdata_i & `BTAPR_MASK_ADV_MID;
        `BTAPR_ADDR_ADV_HIGH:
          adv_high_q <= reg_wdata_i & `BTAPR_MASK_ADV_HIGH;
        `BTAPR_ADDR_NP_LOW:
          np_low_q <= reg_wdata_i & `BTAPR_MASK_NP_LOW;
        default:
          adv_low_q <= adv_low_q;
      endcase
    end
  end

  // Partner page store and page arrived flag
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lp_live_q           <= 48'h0000_0000_0000;
      page_arrived_flag_q <= 1'b0;
    end
    else if (an_reset_i)
    begin
      lp_live_q           <= 48'h0000_0000_0000;
      page_arrived_flag_q <= 1'b0;
    end
    else
    begin
      if (page_valid_i && an_enabled_i)
        lp_live_q <= page_data_i & {`BTAPR_MASK_LP_HIGH,
                                    `BTAPR_MASK_LP_MID,
                                    `BTAPR_MASK_LP_LOW};
      // A new page in the same cycle as the status read wins
      if (page_valid_i && an_enabled_i)
        page_arrived_flag_q <= 1'b1;
      else if (rd_status)
        page_arrived_flag_q <= 1'b0;
    end
  end

  assign local_able = adv_high_q[`BTAPR_BIT_HI_ABL];
  assign local_req  = adv_high_q[`BTAPR_BIT_HI_REQ];
  assign lp_able    = lp_live_q[32+`BTAPR_BIT_HI_ABL];
  assign lp_req     = lp_live_q[32+`BTAPR_BIT_HI_REQ];

  // Read mux; selector of the partner is reported as received
  always @*
  begin
    rdata_d = 16'h0000;
    case (reg_addr_i)
      `BTAPR_ADDR_ADV_LOW:   rdata_d = adv_low_q;
      `BTAPR_ADDR_ADV_MID:   rdata_d = adv_mid_q;
      `BTAPR_ADDR_ADV_HIGH:  rdata_d = adv_high_q;
      `BTAPR_ADDR_LP_LOW:    rdata_d = lp_live_q[15:0];
      `BTAPR_ADDR_LP_MID:    rdata_d = lp_held[15:0];
      `BTAPR_ADDR_LP_HIGH:   rdata_d = lp_held[31:16];
      `BTAPR_ADDR_NP_LOW:    rdata_d = np_low_q;
      `BTAPR_ADDR_AN_STATUS:
        rdata_d = {9'h000, page_arrived_flag_q, 6'h00};
      default:               rdata_d = 16'h0000;
    endcase
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_rdata_o         <= 16'h0000;
      reg_rvalid_o        <= 1'b0;
      local_page_o        <= 48'h0000_0000_0000;
      next_page_low_o     <= 16'h0000;
      page_arrived_flag_o <= 1'b0;
      high_amplitude_o    <= 1'b0;
    end
    else
    begin
      reg_rdata_o         <= reg_rd_i ? rdata_d : 16'h0000;
      reg_rvalid_o        <= reg_rd_i;
      local_page_o        <= {adv_high_q, adv_mid_q, adv_low_q};
      next_page_low_o     <= np_low_q;
      page_arrived_flag_o <= page_arrived_flag_q;
      // Low amplitude unless both able and one side requests
      high_amplitude_o    <= local_able && lp_able
                             && (local_req || lp_req);
    end
  end
endmodule // btapr_regs

// ### tb/btapr_regs_assertions.sv
`timescale 1ns/1ps
`include "btapr_consts.vh"
module btapr_regs_chk (
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        an_reset_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        page_valid_i,
  input wire logic        an_enabled_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic [47:0] local_page_o,
  input wire logic [15:0] next_page_low_o,
  input wire logic        page_arrived_flag_o,
  input wire logic        high_amplitude_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_rd(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_page;
    page_valid_i && an_enabled_i;
  endsequence
  chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  chk_idle_zero: assert property (!reg_rd_i |=> !reg_rvalid_o &&
    reg_rdata_o == 16'h0000) else $error("read bus not idle");
  chk_sel_read: assert property (s_rd(`BTAPR_ADDR_ADV_LOW) |=>
    reg_rdata_o[4:0] == 5'h01) else $error("selector not 00001");
  chk_lp_reserved: assert property (s_rd(`BTAPR_ADDR_LP_LOW) |=>
    (reg_rdata_o & ~`BTAPR_MASK_LP_LOW) == 16'h0000)
    else $error("reserved partner bits set");
  chk_reset_values: assert property (an_reset_i |-> ##[1:2]
    next_page_low_o == 16'h2001 && local_page_o[15:0] == 16'h0001)
    else $error("reset values not restored");
  chk_amp_low: assert property (!local_page_o[45] [*3] |->
    !high_amplitude_o) else $error("high amplitude without ability");
  chk_flag_set: assert property (s_page |-> ##[2:3]
    page_arrived_flag_o) else $error("page flag not set");
  chk_flag_clear: assert property (s_rd(`BTAPR_ADDR_AN_STATUS) ##0
    !page_valid_i && !$past(page_valid_i) |-> ##2 !page_arrived_flag_o)
    else $error("page flag not cleared");
endmodule // btapr_regs_chk
bind btapr_regs btapr_regs_chk btapr_regs_chk_i (.core_clk_i, .arst_n_i,
  .an_reset_i, .reg_rd_i, .reg_addr_i, .page_valid_i, .an_enabled_i,
  .reg_rdata_o, .reg_rvalid_o, .local_page_o, .next_page_low_o,
  .page_arrived_flag_o, .high_amplitude_o);

// ### tb/btapr_partner.sv
`timescale 1ns/1ps
module btapr_partner (
  input  wire logic        core_clk_i,
  input  wire logic        go_i,
  input  wire logic [47:0] page_i,
  output logic             valid_o,
  output logic [47:0]      data_o
);
  initial valid_o = 1'b0;
  initial data_o = 48'h0000_0000_0000;
  always @(posedge core_clk_i)
  begin
    valid_o <= go_i;
    // Between pages the bus toggles so stale data is never trusted
    data_o <= go_i ? {page_i[47:5], 5'h01} : ~data_o;
  end
endmodule // btapr_partner

// ### tb/test_btapr_regs.sv
`timescale 1ns/1ps
`include "btapr_consts.vh"
module test_btapr_regs;
  logic core_clk_i = 0, arst_n_i = 0, an_reset_i = 0, an_enabled_i = 1;
  logic reg_rd_i = 0, reg_wr_i = 0, go = 0, page_valid_i;
  logic reg_rvalid_o, page_arrived_flag_o, high_amplitude_o;
  logic [2:0] strap_pins_i = 3'b111;
  logic [15:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, next_page_low_o;
  logic [15:0] got;
  logic [47:0] pg = 0, page_data_i, local_page_o;
  int err_total = 0, n_compared = 0;
  btapr_regs btapr_regs_i (.core_clk_i, .arst_n_i, .an_reset_i,
    .strap_pins_i, .reg_rd_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .page_valid_i, .page_data_i, .an_enabled_i, .reg_rdata_o, .reg_rvalid_o,
    .local_page_o, .next_page_low_o, .page_arrived_flag_o, .high_amplitude_o);
  btapr_partner btapr_partner_i (.core_clk_i, .go_i(go), .page_i(pg),
    .valid_o(page_valid_i), .data_o(page_data_i));
  always #20 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 got = reg_rdata_o;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    xfer(1'b0, a, 16'h0000);
    chk(got, e);
    chk(reg_rvalid_o, 1'b1);
  endtask
  task automatic send(input logic [47:0] p);
    @(posedge core_clk_i);
    go <= 1'b1;
    pg <= p;
    @(posedge core_clk_i);
    go <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  task automatic clear_flag;
    xfer(1'b0, `BTAPR_ADDR_AN_STATUS, 16'h0000);
    @(posedge core_clk_i);
    #1 chk(page_arrived_flag_o, 1'b0);
  endtask
  task automatic t_reset;
    rd(`BTAPR_ADDR_ADV_LOW, 16'h0001);
    rd(`BTAPR_ADDR_ADV_MID, 16'h4010);
    rd(`BTAPR_ADDR_ADV_HIGH, 16'h3000);
    rd(`BTAPR_ADDR_LP_LOW, 16'h0000);
    rd(`BTAPR_ADDR_NP_LOW, 16'h2001);
    rd(16'h0300, 16'h0000);
    $display("reset values test done");
  endtask
  task automatic t_write;
    xfer(1'b1, `BTAPR_ADDR_ADV_LOW, 16'h7FFF);
    rd(`BTAPR_ADDR_ADV_LOW, 16'h3C01);
    xfer(1'b1, `BTAPR_ADDR_ADV_LOW, 16'h0000);
    rd(`BTAPR_ADDR_ADV_LOW, 16'h0001);
    xfer(1'b1, `BTAPR_ADDR_ADV_MID, 16'hFFFF);
    rd(`BTAPR_ADDR_ADV_MID, 16'h4010);
    xfer(1'b1, `BTAPR_ADDR_ADV_MID, 16'h0000);
    rd(`BTAPR_ADDR_ADV_MID, 16'h0000);
    // Upper next page words live outside this block, so low goes last
    xfer(1'b1, `BTAPR_ADDR_NP_LOW, 16'hFFFF);
    rd(`BTAPR_ADDR_NP_LOW, 16'hB7FF);
    chk(next_page_low_o, 16'hB7FF);
    xfer(1'b1, `BTAPR_ADDR_LP_LOW, 16'hFFFF);
    rd(`BTAPR_ADDR_LP_LOW, 16'h0000);
    chk(local_page_o, 48'h3000_0000_0001);
    $display("write access test done");
  endtask
  task automatic t_snap;
    send(48'h4FFF_C05F_A7EA);
    chk(page_arrived_flag_o, 1'b1);
    clear_flag();
    rd(`BTAPR_ADDR_LP_LOW, 16'hA401);
    send(48'h3000_00A0_5800);
    rd(`BTAPR_ADDR_LP_MID, 16'h4050);
    rd(`BTAPR_ADDR_LP_HIGH, 16'h4800);
    rd(`BTAPR_ADDR_LP_LOW, 16'h5801);
    rd(`BTAPR_ADDR_LP_MID, 16'h00A0);
    rd(`BTAPR_ADDR_LP_HIGH, 16'h3000);
    clear_flag();
    @(posedge core_clk_i);
    an_enabled_i <= 1'b0;
    send(48'h4FFF_C05F_A7EA);
    chk(page_arrived_flag_o, 1'b0);
    rd(`BTAPR_ADDR_LP_LOW, 16'h5801);
    @(posedge core_clk_i);
    an_enabled_i <= 1'b1;
    $display("partner page test done");
  endtask
  task automatic t_amp;
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      xfer(1'b1, `BTAPR_ADDR_ADV_HIGH, {2'b00, c[0], c[1], 12'h000});
      send({2'b00, c[2], c[3], 44'h000_0000_0000});
      chk(high_amplitude_o, c[0] & c[2] & (c[1] | c[3]));
    end
    $display("amplitude test done");
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    // Straps settle through the synchroniser before being recaught
    repeat (4) @(posedge core_clk_i);
    an_reset_i <= 1'b1;
    @(posedge core_clk_i);
    an_reset_i <= 1'b0;
    t_reset();
    t_write();
    t_snap();
    t_amp();
    conclude();
  end
endmodule // test_btapr_regs
